/* verilog/sel_pkg.sv */
// constants, offsets and types of the link error and lock block
package sel_pkg;
  // register offsets
  localparam logic [7:0] SEL_OFS_CFG0      = 8'h00;
  localparam logic [7:0] SEL_OFS_CFG1      = 8'h01;
  localparam logic [7:0] SEL_OFS_CTRL4     = 8'h04;
  localparam logic [7:0] SEL_OFS_PTHR_LO   = 8'h08;
  localparam logic [7:0] SEL_OFS_PTHR_HI   = 8'h09;
  localparam logic [7:0] SEL_OFS_PCNT_LO   = 8'h0a;
  localparam logic [7:0] SEL_OFS_PCNT_HI   = 8'h0b;
  localparam logic [7:0] SEL_OFS_PRBS_CNT  = 8'h0c;
  localparam logic [7:0] SEL_OFS_UART_FLAG = 8'h0d;
  // field positions
  localparam int SEL_BIT_PARITY_EN = 3;
  localparam int SEL_BIT_AER       = 5;
  localparam int SEL_BIT_PRBS_EN   = 0;
  localparam int SEL_BIT_SER_EN    = 3;
  // reset values
  localparam logic [15:0] SEL_RST_PTHR   = 16'hffff;
  localparam logic        SEL_RST_SER_EN = 1'b1;
  localparam logic [14:0] SEL_PRBS_SEED  = 15'h7fff;
  // timing counts in pixel clock words, attempt and error limits
  localparam logic [14:0] SEL_SHORT_WORDS_LO = 15'h0222;
  localparam logic [14:0] SEL_SHORT_WORDS_HI = 15'h0442;
  localparam int          SEL_LONG_WORDS     = 17410;
  localparam logic [1:0]  SEL_SYNC_WORDS     = 2'h3;
  localparam logic [5:0]  SEL_MAX_ATTEMPTS   = 6'h3e;
  localparam int          SEL_LF_WAIT        = 64;
  localparam int          SEL_DEC_WINDOW     = 1024;
  localparam int          SEL_DEC_THRESH     = 8;
  // resynchronization sequencer
  typedef enum logic [2:0] {
    SEL_SEQ_VIDEO,
    SEL_SEQ_CTRL,
    SEL_SEQ_WAIT,
    SEL_SEQ_SHORT,
    SEL_SEQ_LONG,
    SEL_SEQ_SYNC
  } sel_seq_t;
endpackage

/* verilog/sel_link_err.sv */
// error reporting, lock status and resync sequencing of the video link
`timescale 1ns/1ps
module sel_link_err
  import sel_pkg::*;
#(
  parameter int LONG_WORDS = sel_pkg::SEL_LONG_WORDS,
  parameter int DEC_WINDOW = sel_pkg::SEL_DEC_WINDOW,
  parameter int DEC_THRESH = sel_pkg::SEL_DEC_THRESH,
  parameter int LF_WAIT    = sel_pkg::SEL_LF_WAIT
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // decoded register access
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // control channel events
  input  wire logic        cc_open_i,
  input  wire logic        bypass_mode_i,
  input  wire logic        err_frame_valid_i,
  input  wire logic [7:0]  err_frame_data_i,
  // recovered video
  input  wire logic        parity_err_i,
  input  wire logic        prbs_word_valid_i,
  input  wire logic [14:0] prbs_word_i,
  input  wire logic        decode_err_i,
  input  wire logic        handshake_fail_i,
  input  wire logic        sync_detect_i,
  // serializer side of the handshake
  input  wire logic        lock_frame_rx_i,
  input  wire logic [1:0]  pixel_rate_range_i,
  input  wire logic        remote_powerup_select_i,
  output logic             sync_pattern_o,
  output logic             sync_word_o,
  output logic             serialization_enable_o,
  // link status and pins
  output logic             lock_frame_o,
  output logic             ctrl_channel_active_o,
  output logic             loop_hold_o,
  output logic             data_freeze_o,
  output logic             lock_pin_o,
  output logic             lock_oe_n_o,
  output logic             error_pin_o,
  output logic             error_oe_n_o
);
  import sel_pkg::*;

  if (LONG_WORDS < 1091 || LONG_WORDS > 32767 || DEC_WINDOW < 2 ||
      DEC_WINDOW > 65535 || DEC_THRESH < 1 || DEC_THRESH > 254 ||
      LF_WAIT < 1 || LF_WAIT > 65535) begin : g_bad_param
    $error("sel_link_err: parameter out of range");
  end

  //////////////////////////////////////////////////////////////////////////
  // registers and strobes
  logic        par_en_reg, aer_reg, prbs_en_reg, ser_en_reg;
  logic [15:0] pthr_reg, pcnt_reg;
  logic [7:0]  prbs_cnt_reg, uart_reg, rdata_reg;
  logic        par_flag_reg, lock_reg, cc_reg, lock_frame_reg;
  logic        rem_meta_reg, rem_sync_reg;
  logic [14:0] lfsr_reg;
  logic [15:0] win_cnt_reg;
  logic [7:0]  dec_cnt_reg;
  sel_seq_t    seq_reg;
  logic [14:0] seq_cnt_reg, seq_len_reg;
  logic [5:0]  miss_reg;
  logic        cc_close, par_inc, uart_rd, pcnt_rd, prbs_clr, auto_clr;
  logic [15:0] pcnt_next;
  logic [7:0]  rd_mux;

  assign cc_close = cc_reg & ~cc_open_i;
  assign uart_rd  = reg_rd_i && reg_addr_i == SEL_OFS_UART_FLAG;
  // the high byte is read last, so its read clears the whole count
  assign pcnt_rd  = reg_rd_i && reg_addr_i == SEL_OFS_PCNT_HI;
  assign prbs_clr = reg_wr_i && reg_addr_i == SEL_OFS_CTRL4 &&
                    !reg_wdata_i[SEL_BIT_PRBS_EN];
  assign auto_clr = aer_reg & cc_close;
  assign par_inc  = parity_err_i & par_en_reg & ~cc_open_i;
  assign pcnt_next = (pcnt_reg == 16'hffff) ? pcnt_reg
                                            : pcnt_reg + 16'h0001;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      par_en_reg  <= 1'b0;
      aer_reg     <= 1'b0;
      prbs_en_reg <= 1'b0;
      pthr_reg    <= SEL_RST_PTHR;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        SEL_OFS_CFG0:    par_en_reg <= reg_wdata_i[SEL_BIT_PARITY_EN];
        SEL_OFS_CFG1:    aer_reg <= reg_wdata_i[SEL_BIT_AER];
        SEL_OFS_CTRL4:   prbs_en_reg <= reg_wdata_i[SEL_BIT_PRBS_EN];
        SEL_OFS_PTHR_LO: pthr_reg[7:0] <= reg_wdata_i;
        SEL_OFS_PTHR_HI: pthr_reg[15:8] <= reg_wdata_i;
        default:         pthr_reg <= pthr_reg;
      endcase
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      SEL_OFS_CFG0:      rd_mux[SEL_BIT_PARITY_EN] = par_en_reg;
      SEL_OFS_CFG1:      rd_mux[SEL_BIT_AER] = aer_reg;
      SEL_OFS_CTRL4: begin
        rd_mux[SEL_BIT_PRBS_EN] = prbs_en_reg;
        rd_mux[SEL_BIT_SER_EN]  = ser_en_reg;
      end
      SEL_OFS_PTHR_LO:   rd_mux = pthr_reg[7:0];
      SEL_OFS_PTHR_HI:   rd_mux = pthr_reg[15:8];
      SEL_OFS_PCNT_LO:   rd_mux = pcnt_reg[7:0];
      SEL_OFS_PCNT_HI:   rd_mux = pcnt_reg[15:8];
      SEL_OFS_PRBS_CNT:  rd_mux = prbs_cnt_reg;
      SEL_OFS_UART_FLAG: rd_mux = uart_reg;
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_reg <= rd_mux;
    end
  end
  assign reg_rdata_o = rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // uart error flags; a frame landing with the clearing read is kept
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      uart_reg <= 8'h00;
    end else if (err_frame_valid_i) begin
      // far end restarts its record each session, so or-in accumulates
      if (uart_rd || auto_clr) begin
        uart_reg <= err_frame_data_i;
      end else begin
        uart_reg <= uart_reg | err_frame_data_i;
      end
    end else if (uart_rd || auto_clr) begin
      uart_reg <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // video parity count and threshold flag
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pcnt_reg <= 16'h0000;
    end else if (par_inc) begin
      pcnt_reg <= (pcnt_rd || auto_clr) ? 16'h0001 : pcnt_next;
    end else if (pcnt_rd || auto_clr) begin
      pcnt_reg <= 16'h0000;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      par_flag_reg <= 1'b0;
    end else if (par_inc && pcnt_next >= pthr_reg) begin
      par_flag_reg <= 1'b1;
    end else if (cc_close) begin
      par_flag_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // prbs checker; x^15 + x^14 + 1, one step per received word
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lfsr_reg     <= SEL_PRBS_SEED;
      prbs_cnt_reg <= 8'h00;
    end else if (prbs_clr) begin
      lfsr_reg     <= SEL_PRBS_SEED;
      prbs_cnt_reg <= 8'h00;
    end else if (prbs_en_reg && prbs_word_valid_i) begin
      lfsr_reg <= {lfsr_reg[13:0], lfsr_reg[14] ^ lfsr_reg[13]};
      if (prbs_word_i != lfsr_reg && prbs_cnt_reg != 8'hff) begin
        prbs_cnt_reg <= prbs_cnt_reg + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // lock tracking; decode errors are counted per window of video time
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      win_cnt_reg <= 16'h0000;
      dec_cnt_reg <= 8'h00;
    end else if (cc_open_i || win_cnt_reg == 16'(DEC_WINDOW - 1)) begin
      win_cnt_reg <= 16'h0000;
      dec_cnt_reg <= 8'h00;
    end else begin
      win_cnt_reg <= win_cnt_reg + 16'h0001;
      if (decode_err_i && dec_cnt_reg != 8'hff) begin
        dec_cnt_reg <= dec_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_reg <= 1'b0;
    end else if (handshake_fail_i || dec_cnt_reg > 8'(DEC_THRESH)) begin
      lock_reg <= 1'b0;
    end else if (sync_detect_i) begin
      lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cc_reg         <= 1'b0;
      lock_frame_reg <= 1'b0;
    end else begin
      cc_reg         <= cc_open_i;
      lock_frame_reg <= cc_close & lock_reg;
    end
  end

  // frozen outputs and held loop keep lock valid across the control phase
  assign ctrl_channel_active_o = cc_reg;
  assign loop_hold_o   = cc_reg;
  assign data_freeze_o = cc_reg;
  assign lock_frame_o  = lock_frame_reg;
  assign lock_pin_o    = 1'b0;
  assign lock_oe_n_o   = lock_reg;

  assign error_pin_o  = 1'b0;
  assign error_oe_n_o = ~((uart_reg != 8'h00 && lock_reg) ||
                          (par_flag_reg && (!bypass_mode_i || aer_reg)) ||
                          prbs_cnt_reg != 8'h00);

  //////////////////////////////////////////////////////////////////////////
  // resynchronization sequencer; power-up starts with the long pattern
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rem_meta_reg <= 1'b0;
      rem_sync_reg <= 1'b0;
    end else begin
      rem_meta_reg <= remote_powerup_select_i;
      rem_sync_reg <= rem_meta_reg;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_reg     <= SEL_SEQ_LONG;
      seq_cnt_reg <= 15'h0000;
      seq_len_reg <= 15'(LONG_WORDS);
      miss_reg    <= 6'h00;
      ser_en_reg  <= SEL_RST_SER_EN;
    end else begin
      seq_cnt_reg <= seq_cnt_reg + 15'h0001;
      if (reg_wr_i && reg_addr_i == SEL_OFS_CTRL4) begin
        ser_en_reg <= reg_wdata_i[SEL_BIT_SER_EN];
      end
      case (seq_reg)
        SEL_SEQ_VIDEO: begin
          if (cc_open_i || !ser_en_reg) begin
            seq_reg <= SEL_SEQ_CTRL;
          end
        end
        SEL_SEQ_CTRL: begin
          seq_cnt_reg <= 15'h0000;
          if (!cc_open_i && ser_en_reg) begin
            seq_reg <= SEL_SEQ_WAIT;
          end
        end
        SEL_SEQ_WAIT: begin
          if (lock_frame_rx_i) begin
            seq_reg     <= SEL_SEQ_SHORT;
            seq_cnt_reg <= 15'h0000;
            miss_reg    <= 6'h00;
            seq_len_reg <= pixel_rate_range_i[1] ? SEL_SHORT_WORDS_HI
                                                 : SEL_SHORT_WORDS_LO;
          end else if (seq_cnt_reg == 15'(LF_WAIT - 1)) begin
            seq_reg     <= SEL_SEQ_LONG;
            seq_cnt_reg <= 15'h0000;
            seq_len_reg <= 15'(LONG_WORDS);
            if (miss_reg != SEL_MAX_ATTEMPTS) begin
              miss_reg <= miss_reg + 6'h01;
            end
            // a count saturated while the pin was low still trips later
            if (rem_sync_reg && miss_reg >= SEL_MAX_ATTEMPTS - 6'h01) begin
              seq_reg    <= SEL_SEQ_CTRL;
              miss_reg   <= 6'h00;
              ser_en_reg <= 1'b0;
            end
          end
        end
        SEL_SEQ_SHORT, SEL_SEQ_LONG: begin
          if (seq_cnt_reg == seq_len_reg - 15'h0001) begin
            seq_reg     <= SEL_SEQ_SYNC;
            seq_cnt_reg <= 15'h0000;
          end
        end
        SEL_SEQ_SYNC: begin
          if (seq_cnt_reg == 15'(SEL_SYNC_WORDS - 2'h1)) begin
            seq_reg <= SEL_SEQ_VIDEO;
          end
        end
        default: seq_reg <= SEL_SEQ_CTRL;
      endcase
    end
  end

  assign sync_pattern_o = seq_reg == SEL_SEQ_SHORT ||
                          seq_reg == SEL_SEQ_LONG;
  assign sync_word_o    = seq_reg == SEL_SEQ_SYNC;
  assign serialization_enable_o = ser_en_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks; pattern runs are counted, far too long to unroll in a property
  logic [14:0] short_run_reg;
  logic        short_hi_reg;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      short_run_reg <= 15'h0000;
      short_hi_reg  <= 1'b0;
    end else begin
      if (seq_reg == SEL_SEQ_SHORT) begin
        short_run_reg <= short_run_reg + 15'h0001;
      end else begin
        short_run_reg <= 15'h0000;
      end
      if (seq_reg == SEL_SEQ_WAIT && lock_frame_rx_i) begin
        short_hi_reg <= pixel_rate_range_i[1];
      end
    end
  end

  a_uart_read_clr: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    uart_rd && !err_frame_valid_i |=> uart_reg == 8'h00)
    else $error("uart flags not cleared by read");

  a_uart_unlocked: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    !lock_reg && !par_flag_reg && prbs_cnt_reg == 8'h00 |-> error_oe_n_o)
    else $error("error output driven while unlocked");

  a_prbs_err_out: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    prbs_cnt_reg != 8'h00 |-> !error_oe_n_o)
    else $error("prbs errors not on error output");

  a_prbs_clear: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    prbs_clr |=> prbs_cnt_reg == 8'h00 ##1 prbs_cnt_reg <= 8'h01)
    else $error("prbs count not cleared");

  a_par_count_inc: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    par_inc && !pcnt_rd && !auto_clr && pcnt_reg != 16'hffff
    |=> pcnt_reg == $past(pcnt_reg) + 16'h0001)
    else $error("parity count did not step");

  a_lock_frame_out: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    cc_close && lock_reg |=> lock_frame_o ##1 !lock_frame_o)
    else $error("lock frame not sent once");

  a_lock_loss: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    handshake_fail_i |=> !lock_oe_n_o)
    else $error("lock kept after handshake failure");

  a_sync_words: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    seq_reg != SEL_SEQ_SYNC ##1 seq_reg == SEL_SEQ_SYNC
    |-> seq_reg == SEL_SEQ_SYNC [*3] ##1 seq_reg == SEL_SEQ_VIDEO)
    else $error("sync words not three");

  a_short_len: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    seq_reg == SEL_SEQ_SHORT ##1 seq_reg != SEL_SEQ_SHORT
    |-> seq_reg == SEL_SEQ_SYNC && short_run_reg ==
        (short_hi_reg ? SEL_SHORT_WORDS_HI : SEL_SHORT_WORDS_LO))
    else $error("short pattern length wrong");

  a_ser_en_drop: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    seq_reg == SEL_SEQ_WAIT && !lock_frame_rx_i && rem_sync_reg &&
    seq_cnt_reg == 15'(LF_WAIT - 1) && miss_reg == SEL_MAX_ATTEMPTS - 6'h01
    |=> !serialization_enable_o && seq_reg == SEL_SEQ_CTRL)
    else $error("serialization not disabled");
endmodule

/* dv/sel_ser_model.sv */
// behavioural serializer peer seen across the serial video link
`timescale 1ns/1ps
module sel_ser_model (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // bench controls
  input  wire logic       echo_en_i,
  input  wire logic       send_err_i,
  input  wire logic [7:0] err_data_i,
  // link from the deserializer
  input  wire logic       lock_frame_i,
  input  wire logic       sync_word_i,
  // link towards the deserializer
  output logic            lock_frame_rx_o,
  output logic            sync_detect_o,
  output logic            err_frame_valid_o,
  output logic [7:0]      err_frame_data_o
);
  logic sync_word_reg;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_frame_rx_o   <= 1'b0;
      sync_detect_o     <= 1'b0;
      err_frame_valid_o <= 1'b0;
      err_frame_data_o  <= 8'h00;
      sync_word_reg     <= 1'b0;
    end else begin
      // the echo lands one edge later, well inside the wait window
      lock_frame_rx_o   <= echo_en_i & lock_frame_i;
      sync_word_reg     <= sync_word_i;
      sync_detect_o     <= sync_word_reg & ~sync_word_i;
      err_frame_valid_o <= send_err_i;
      // only this session's flags are sent; idle data toggles, no hold
      err_frame_data_o  <= send_err_i ? err_data_i
                                      : ~err_frame_data_o;
    end
  end
endmodule

/* dv/tb.sv */
// self-checking bench of the link error and lock block
`timescale 1ns/1ps
module tb;
  import sel_pkg::*;
  localparam int LONG = 1200;
  logic        clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, cc_open_i;
  logic        bypass_mode_i, efv, parity_err_i, prbs_word_valid_i;
  logic        decode_err_i, hs_fail, sync_det, lf_rx, rem_sel;
  logic        sync_pattern_o, sync_word_o, serialization_enable_o;
  logic        lock_frame_o, ctrl_channel_active_o, loop_hold_o;
  logic        data_freeze_o, lock_oe_n_o, error_oe_n_o, echo_en;
  logic        send_err;
  logic [1:0]  pixel_rate_range_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, efd, err_data;
  logic [14:0] prbs_word_i;
  int          error_cnt, checks, cyc_cnt;

  sel_link_err #(.LONG_WORDS(LONG), .LF_WAIT(4)) sel_link_err_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .cc_open_i(cc_open_i), .bypass_mode_i(bypass_mode_i),
    .err_frame_valid_i(efv), .err_frame_data_i(efd),
    .parity_err_i(parity_err_i), .prbs_word_valid_i(prbs_word_valid_i),
    .prbs_word_i(prbs_word_i), .decode_err_i(decode_err_i),
    .handshake_fail_i(hs_fail), .sync_detect_i(sync_det),
    .lock_frame_rx_i(lf_rx), .pixel_rate_range_i(pixel_rate_range_i),
    .remote_powerup_select_i(rem_sel), .sync_pattern_o(sync_pattern_o),
    .sync_word_o(sync_word_o),
    .serialization_enable_o(serialization_enable_o),
    .lock_frame_o(lock_frame_o),
    .ctrl_channel_active_o(ctrl_channel_active_o),
    .loop_hold_o(loop_hold_o), .data_freeze_o(data_freeze_o),
    .lock_pin_o(), .lock_oe_n_o(lock_oe_n_o), .error_pin_o(),
    .error_oe_n_o(error_oe_n_o));

  sel_ser_model sel_ser_model_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .echo_en_i(echo_en),
    .send_err_i(send_err), .err_data_i(err_data),
    .lock_frame_i(lock_frame_o), .sync_word_i(sync_word_o),
    .lock_frame_rx_o(lf_rx), .sync_detect_o(sync_det),
    .err_frame_valid_o(efv), .err_frame_data_o(efd));

  //////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // two edges after the strobe the read data and its side effects settle
  task automatic rdc(input logic [7:0] a, exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk($sformatf("reg %h", a), 16'(reg_rdata_o), 16'(exp));
  endtask

  task automatic par(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      parity_err_i <= 1'b1;
    end
    @(posedge clk_sys_i);
    parity_err_i <= 1'b0;
    cyc(2);
    #1;
  endtask

  task automatic frame(input logic [7:0] d);
    @(posedge clk_sys_i);
    send_err <= 1'b1;
    err_data <= d;
    @(posedge clk_sys_i);
    send_err <= 1'b0;
    cyc(3);
    #1;
  endtask

  // one control session, then the pattern and sync words are counted
  task automatic session(input logic lk, input logic [1:0] rate,
                         input logic ef, input int exp_n);
    int n;
    int w;
    n = 0;
    w = 0;
    @(posedge clk_sys_i);
    pixel_rate_range_i <= rate;
    cc_open_i          <= 1'b1;
    cyc(4);
    #1;
    chk("cc_active", 16'(ctrl_channel_active_o), 16'h1);
    chk("hold", 16'({loop_hold_o, data_freeze_o}), 16'h3);
    chk("lock_cc", 16'(lock_oe_n_o), 16'(lk));
    if (ef) frame(8'h05);
    @(posedge clk_sys_i);
    cc_open_i <= 1'b0;
    repeat (LONG + 100) begin
      @(posedge clk_sys_i);
      #1;
      if (sync_pattern_o === 1'b1) n++;
      if (sync_word_o === 1'b1) w++;
      if (w > 0 && sync_word_o !== 1'b1) break;
    end
    chk("pattern", 16'(n), 16'(exp_n));
    chk("sync", 16'(w), 16'h3);
    cyc(3);
    #1;
    chk("cc_video", 16'(ctrl_channel_active_o), 16'h0);
    chk("relock", 16'(lock_oe_n_o), 16'h1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    {sys_rst_i, echo_en} = 2'b11;
    {reg_wr_i, reg_rd_i, cc_open_i, bypass_mode_i, send_err} = 5'h0;
    {parity_err_i, prbs_word_valid_i, decode_err_i, hs_fail} = 4'h0;
    {rem_sel, pixel_rate_range_i, reg_addr_i, reg_wdata_i} = 19'h0;
    {err_data, prbs_word_i} = 23'h0;
    cyc(12);
    chk("rst_lock", 16'(lock_oe_n_o), 16'h0);
    chk("rst_err", 16'(error_oe_n_o), 16'h1);
    sys_rst_i <= 1'b0;
    cyc(LONG + 20);
    #1;
    chk("first_lock", 16'(lock_oe_n_o), 16'h1);
    rdc(SEL_OFS_PTHR_LO, 8'hff);
    rdc(SEL_OFS_PTHR_HI, 8'hff);
    rdc(8'h20, 8'h00);
    wr(SEL_OFS_PRBS_CNT, 8'h55);
    rdc(SEL_OFS_PRBS_CNT, 8'h00);
    // uart flags from the error frame, then every rate range
    session(1'b1, 2'b00, 1'b1, 546);
    chk("uart_err", 16'(error_oe_n_o), 16'h0);
    rdc(SEL_OFS_UART_FLAG, 8'h05);
    chk("uart_clr", 16'(error_oe_n_o), 16'h1);
    for (int r = 1; r < 4; r++) begin
      session(1'b1, r[1:0], 1'b0, r[1] ? 1090 : 546);
    end
    // parity threshold, accumulation and clear by read
    wr(SEL_OFS_CFG0, 8'h08);
    wr(SEL_OFS_PTHR_LO, 8'h02);
    wr(SEL_OFS_PTHR_HI, 8'h00);
    par(1);
    chk("par_below", 16'(error_oe_n_o), 16'h1);
    par(1);
    chk("par_at", 16'(error_oe_n_o), 16'h0);
    rdc(SEL_OFS_PCNT_LO, 8'h02);
    session(1'b1, 2'b00, 1'b0, 546);
    chk("par_video", 16'(error_oe_n_o), 16'h1);
    par(1);
    rdc(SEL_OFS_PCNT_LO, 8'h03);
    rdc(SEL_OFS_PCNT_HI, 8'h00);
    rdc(SEL_OFS_PCNT_LO, 8'h00);
    session(1'b1, 2'b00, 1'b0, 546);
    // bypass reporting needs auto reset
    bypass_mode_i <= 1'b1;
    par(2);
    chk("byp_mask", 16'(error_oe_n_o), 16'h1);
    wr(SEL_OFS_CFG1, 8'h20);
    par(1);
    chk("byp_aer", 16'(error_oe_n_o), 16'h0);
    bypass_mode_i <= 1'b0;
    // a zero word never matches the generator, so one miss is counted
    wr(SEL_OFS_CTRL4, 8'h09);
    @(posedge clk_sys_i);
    prbs_word_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    prbs_word_valid_i <= 1'b0;
    session(1'b1, 2'b00, 1'b0, 546);
    rdc(SEL_OFS_PCNT_LO, 8'h00);
    rdc(SEL_OFS_PRBS_CNT, 8'h01);
    chk("prbs_err", 16'(error_oe_n_o), 16'h0);
    wr(SEL_OFS_CTRL4, 8'h08);
    cyc(1);
    #1;
    chk("prbs_off", 16'(error_oe_n_o), 16'h1);
    rdc(SEL_OFS_PRBS_CNT, 8'h00);
    // auto reset off again, or the held uart flags vanish at the close
    wr(SEL_OFS_CFG1, 8'h00);
    // decode burst drops lock; uart flags are held back while unlocked
    @(posedge clk_sys_i);
    decode_err_i <= 1'b1;
    cyc(SEL_DEC_THRESH + 1);
    decode_err_i <= 1'b0;
    cyc(2);
    #1;
    chk("unlock", 16'(lock_oe_n_o), 16'h0);
    frame(8'h02);
    chk("no_uart", 16'(error_oe_n_o), 16'h1);
    session(1'b0, 2'b00, 1'b0, LONG);
    chk("uart_lock", 16'(error_oe_n_o), 16'h0);
    rdc(SEL_OFS_UART_FLAG, 8'h02);
    chk("ser_en", 16'(serialization_enable_o), 16'h1);
    // a failed handshake alone drops lock
    @(posedge clk_sys_i);
    hs_fail <= 1'b1;
    @(posedge clk_sys_i);
    hs_fail <= 1'b0;
    cyc(1);
    #1;
    chk("hs_unlock", 16'(lock_oe_n_o), 16'h0);
    conclude();
  end
endmodule
